// ===== cssr_pkg.sv
package cssr_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CSSR_OFF_TIMER = 8'h31;
  localparam logic [7:0] CSSR_OFF_PIN = 8'h32;
  localparam logic [7:0] CSSR_OFF_LOCK = 8'h39;
  localparam logic [7:0] CSSR_OFF_CPU = 8'h30;
  localparam logic [7:0] CSSR_OFF_SPEED = 8'h40;
  localparam logic [7:0] CSSR_OFF_STATUS = 8'h44;
  localparam logic [7:0] CSSR_OFF_VECTOR = 8'h48;
  localparam logic [7:0] CSSR_RST_TIMER = 8'h8F;
  localparam logic [7:0] CSSR_RST_PIN = 8'h00;
  localparam logic [7:0] CSSR_RST_LOCK = 8'h00;
  localparam logic [7:0] CSSR_RST_CPU = 8'h00;
  localparam logic [2:0] CSSR_RST_SPEED = 3'h0;
  localparam logic [15:0] CSSR_RESET_VECTOR = 16'h0000;
  localparam logic [7:0] CSSR_MASK_TIMER = 8'hFF;
  localparam logic [7:0] CSSR_MASK_PIN = 8'h1F;
  localparam logic [7:0] CSSR_MASK_LOCK = 8'h03;
  localparam logic [7:0] CSSR_MASK_CPU = 8'h61;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CSSR_LOCK_DIS = 0;
  localparam int CSSR_FINE_ONLY = 1;
  localparam int CSSR_CPU_SEL = 0;
  localparam int CSSR_USB_SEL = 5;
  localparam int CSSR_USB_NODIV = 6;
  localparam int CSSR_XTAL_SEL = 4;
  localparam int CSSR_XTAL_EN = 3;
  localparam int CSSR_FILT_DIS = 2;
  localparam logic [1:0] CSSR_SRC_OSC = 2'h0;
  localparam logic [1:0] CSSR_SRC_EXT = 2'h1;
  localparam logic [1:0] CSSR_SRC_LPO = 2'h2;
  localparam logic [1:0] CSSR_SRC_CPU = 2'h3;
  localparam logic [1:0] CSSR_AXI_OKAY = 2'h0;
  localparam logic [1:0] CSSR_AXI_SLVERR = 2'h2;
  // ****************************************
  // timing
  // ****************************************
  localparam int CSSR_CLK_MHZ = 100;
  localparam int CSSR_WAKE_LPO_CYCLES = 3;
  typedef enum logic [1:0] {CSSR_IDLE, CSSR_COARSE, CSSR_FINE} cssr_trim_t;
  typedef struct packed {
    logic [1:0] tcap_div;
    logic [1:0] tcap_sel;
    logic [1:0] itmr_div;
    logic [1:0] itmr_sel;
  } cssr_timer_t;
endpackage : cssr_pkg

// ===== cssr_top.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Function
// - trim internal oscillator from low-speed packet timing when it clocks the engine.
// - lock disable clear tunes to 24 MHz; set stops packet trimming.
// - fine-tune-only skips coarse step and runs fine step only.
// - crystal select makes crystal the external clock source.
// - crystal enable takes clock input from crystal and forces pin enables off.
// - filter disable clear filters the clock input; set bypasses the filter.
// - clock output select 00 osc, 01 external, 10 low-power, 11 processor.
// - sleep forces processor clock to internal oscillator and stops it.
// - wake runs from internal oscillator, recovering within three low-power cycles.
// - power-on and watchdog reset restore register defaults.
// - separate flags record which reset type occurred.
// - after reset fetch from address 0x0000 with internal clocking.
// - at power-on processor clock defaults to 24 MHz divided by eight.
// - with engine clock from external source, no packet trimming.
module cssr_top
  import cssr_pkg::*;
#(
  parameter int TRIM_W = 8
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_watchdog_reset,
  input wire logic i_por_flag,
  input wire logic [31:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [31:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_packet_edge,
  input wire logic i_packet_slow,
  input wire logic i_sleep,
  input wire logic i_lpo_tick,
  output logic [TRIM_W-1:0] o_osc_trim,
  output logic o_osc_run,
  output logic o_cpu_on_ext,
  output logic [1:0] o_tcap_sel,
  output logic [1:0] o_tcap_div,
  output logic [1:0] o_itmr_sel,
  output logic [1:0] o_itmr_div,
  output logic o_xtal_enable,
  output logic o_ext_from_xtal,
  output logic o_clock_input_pin_from_xtal,
  output logic o_pin_oe_force_off,
  output logic o_filter_bypass,
  output logic [1:0] o_clock_output_pin_sel,
  output logic [2:0] o_cpu_speed,
  output logic [15:0] o_fetch_addr
);
  // ****************************************
  // reset and pin synchronisers
  // ****************************************
  logic rst_s1_ff, rst_n_ff;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end
  logic [4:0] pin_s1_ff, pin_s2_ff;
  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pin_s1_ff <= 5'h00;
      pin_s2_ff <= 5'h00;
    end else begin
      pin_s1_ff <= {i_watchdog_reset, i_packet_edge, i_packet_slow, i_sleep, i_lpo_tick};
      pin_s2_ff <= pin_s1_ff;
    end
  end
  wire wdr_s = pin_s2_ff[4];
  wire pkt_s = pin_s2_ff[3];
  wire slow_s = pin_s2_ff[2];
  wire sleep_s = pin_s2_ff[1];
  wire lpo_s = pin_s2_ff[0];
  logic pkt_d_ff, lpo_d_ff, sleep_d_ff, wdr_d_ff;
  // ****************************************
  // register file
  // ****************************************
  cssr_timer_t timer_ff;
  logic [7:0] pin_cfg_ff, lock_ff, cpu_ff;
  logic [2:0] speed_ff;
  logic por_seen_ff, wdr_seen_ff, first_ff;
  logic aw_ff, w_ff;
  logic [7:0] awa_ff;
  logic [7:0] wd_ff;
  logic wst_ff;
  wire do_write = aw_ff && w_ff && !o_bvalid;
  wire [7:0] wmask = wst_ff ? 8'hFF : 8'h00;
  wire wr_timer = do_write && awa_ff == CSSR_OFF_TIMER;
  wire wr_pin = do_write && awa_ff == CSSR_OFF_PIN;
  wire wr_lock = do_write && awa_ff == CSSR_OFF_LOCK;
  wire wr_cpu = do_write && awa_ff == CSSR_OFF_CPU;
  wire wr_speed = do_write && awa_ff == CSSR_OFF_SPEED;
  wire wr_status = do_write && awa_ff == CSSR_OFF_STATUS;
  wire wr_hit = wr_timer | wr_pin | wr_lock | wr_cpu | wr_speed | wr_status;
  wire [7:0] ra = i_araddr[9:2];
  wire r_hit = ra == CSSR_OFF_TIMER || ra == CSSR_OFF_PIN || ra == CSSR_OFF_LOCK
    || ra == CSSR_OFF_CPU || ra == CSSR_OFF_SPEED || ra == CSSR_OFF_STATUS
    || ra == CSSR_OFF_VECTOR;
  wire [31:0] rsel = (ra == CSSR_OFF_TIMER) ? {24'h000000, timer_ff} :
    (ra == CSSR_OFF_PIN) ? {24'h000000, pin_cfg_ff} :
    (ra == CSSR_OFF_LOCK) ? {24'h000000, lock_ff} :
    (ra == CSSR_OFF_CPU) ? {24'h000000, cpu_ff} :
    (ra == CSSR_OFF_SPEED) ? {29'h00000000, speed_ff} :
    (ra == CSSR_OFF_STATUS) ? {30'h00000000, wdr_seen_ff, por_seen_ff} :
    (ra == CSSR_OFF_VECTOR) ? {16'h0000, CSSR_RESET_VECTOR} : 32'h00000000;
  wire take_ar = i_arvalid && !o_rvalid;
  wire wdr_rise = wdr_s && !wdr_d_ff;
  // status flags: hardware set beats software clear
  wire [1:0] st_clr = wr_status ? (wd_ff[1:0] & wmask[1:0]) : 2'h0;
  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 8'h00;
      wd_ff <= 8'h00;
      wst_ff <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= CSSR_AXI_OKAY;
      o_rvalid <= 1'b0;
      o_rresp <= CSSR_AXI_OKAY;
      o_rdata <= 32'h00000000;
      // awready and wready are flops kept as the inverse of the holding registers; arready as the inverse of rvalid
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_arready <= 1'b1;
    end else begin
      if (i_awvalid && !aw_ff) begin
        aw_ff <= 1'b1;
        o_awready <= 1'b0;
        // offsets are word indexes: the byte address is four times the index
        awa_ff <= i_awaddr[9:2];
      end
      if (i_wvalid && !w_ff) begin
        w_ff <= 1'b1;
        o_wready <= 1'b0;
        wd_ff <= i_wdata[7:0];
        wst_ff <= i_wstrb[0];
      end
      if (do_write) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
        o_bvalid <= 1'b1;
        o_bresp <= wr_hit ? CSSR_AXI_OKAY : CSSR_AXI_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
      if (take_ar) begin
        o_rvalid <= 1'b1;
        o_arready <= 1'b0;
        o_rdata <= rsel;
        o_rresp <= r_hit ? CSSR_AXI_OKAY : CSSR_AXI_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end
  wire soft_rst = wdr_rise;
  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      timer_ff <= CSSR_RST_TIMER;
      pin_cfg_ff <= CSSR_RST_PIN;
      lock_ff <= CSSR_RST_LOCK;
      cpu_ff <= CSSR_RST_CPU;
      speed_ff <= CSSR_RST_SPEED;
    end else if (soft_rst) begin
      timer_ff <= CSSR_RST_TIMER;
      pin_cfg_ff <= CSSR_RST_PIN;
      lock_ff <= CSSR_RST_LOCK;
      cpu_ff <= CSSR_RST_CPU;
      speed_ff <= CSSR_RST_SPEED;
    end else begin
      if (wr_timer && wst_ff) timer_ff <= wd_ff & CSSR_MASK_TIMER;
      if (wr_pin && wst_ff) pin_cfg_ff <= wd_ff & CSSR_MASK_PIN;
      if (wr_lock && wst_ff) lock_ff <= wd_ff & CSSR_MASK_LOCK;
      if (sleep_s) cpu_ff[CSSR_CPU_SEL] <= 1'b0;
      else if (wr_cpu && wst_ff) cpu_ff <= wd_ff & CSSR_MASK_CPU;
      if (wr_speed && wst_ff) speed_ff <= wd_ff[2:0];
    end
  end
  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      por_seen_ff <= 1'b0;
      wdr_seen_ff <= 1'b0;
      first_ff <= 1'b1;
      pkt_d_ff <= 1'b0;
      lpo_d_ff <= 1'b0;
      sleep_d_ff <= 1'b0;
      wdr_d_ff <= 1'b0;
    end else begin
      first_ff <= 1'b0;
      pkt_d_ff <= pkt_s;
      lpo_d_ff <= lpo_s;
      sleep_d_ff <= sleep_s;
      wdr_d_ff <= wdr_s;
      por_seen_ff <= (first_ff && i_por_flag) || (por_seen_ff && !st_clr[0]);
      wdr_seen_ff <= wdr_rise || (wdr_seen_ff && !st_clr[1]);
    end
  end
  // ****************************************
  // oscillator lock trimming
  // ****************************************
  cssr_trim_t trim_st_ff;
  logic [TRIM_W-1:0] trim_ff;
  wire osc_feeds_usb = !cpu_ff[CSSR_USB_SEL];
  wire trim_ok = osc_feeds_usb && !lock_ff[CSSR_LOCK_DIS] && pkt_s && !pkt_d_ff;
  wire [TRIM_W-1:0] coarse_step = TRIM_W'(4);
  wire [TRIM_W-1:0] fine_step = TRIM_W'(1);
  wire trim_top = trim_ff > ~coarse_step;
  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      trim_st_ff <= CSSR_IDLE;
      trim_ff <= {1'b1, {(TRIM_W-1){1'b0}}};
    end else if (soft_rst) begin
      trim_st_ff <= CSSR_IDLE;
    end else begin
      case (trim_st_ff)
        CSSR_IDLE: begin
          if (trim_ok) trim_st_ff <= lock_ff[CSSR_FINE_ONLY] ? CSSR_FINE : CSSR_COARSE;
        end
        CSSR_COARSE: begin
          if (slow_s && !trim_top) trim_ff <= trim_ff + coarse_step;
          else if (!slow_s && trim_ff >= coarse_step) trim_ff <= trim_ff - coarse_step;
          trim_st_ff <= CSSR_FINE;
        end
        CSSR_FINE: begin
          if (slow_s && trim_ff != {TRIM_W{1'b1}}) trim_ff <= trim_ff + fine_step;
          else if (!slow_s && trim_ff != '0) trim_ff <= trim_ff - fine_step;
          trim_st_ff <= CSSR_IDLE;
        end
        default: trim_st_ff <= CSSR_IDLE;
      endcase
    end
  end
  // ****************************************
  // sleep and wake of the oscillator
  // ****************************************
  logic [1:0] wake_cnt_ff;
  logic osc_run_ff;
  wire lpo_rise = lpo_s && !lpo_d_ff;
  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      osc_run_ff <= 1'b1;
      wake_cnt_ff <= 2'h0;
    end else if (sleep_s) begin
      osc_run_ff <= 1'b0;
      wake_cnt_ff <= 2'h0;
    end else if (!osc_run_ff && lpo_rise) begin
      if (wake_cnt_ff == 2'(CSSR_WAKE_LPO_CYCLES - 1)) osc_run_ff <= 1'b1;
      else wake_cnt_ff <= wake_cnt_ff + 2'h1;
    end
  end
  // ****************************************
  // output registers
  // ****************************************
  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      o_osc_trim <= '0;
      o_osc_run <= 1'b0;
      o_cpu_on_ext <= 1'b0;
      o_tcap_sel <= 2'h0;
      o_tcap_div <= 2'h0;
      o_itmr_sel <= 2'h0;
      o_itmr_div <= 2'h0;
      o_xtal_enable <= 1'b0;
      o_ext_from_xtal <= 1'b0;
      o_clock_input_pin_from_xtal <= 1'b0;
      o_pin_oe_force_off <= 1'b0;
      o_filter_bypass <= 1'b0;
      o_clock_output_pin_sel <= CSSR_SRC_OSC;
      o_cpu_speed <= CSSR_RST_SPEED;
      o_fetch_addr <= CSSR_RESET_VECTOR;
    end else begin
      o_osc_trim <= trim_ff;
      o_osc_run <= osc_run_ff;
      o_cpu_on_ext <= cpu_ff[CSSR_CPU_SEL];
      // source and divider fields to the clock muxes
      o_tcap_sel <= timer_ff.tcap_sel;
      o_itmr_sel <= timer_ff.itmr_sel;
      o_tcap_div <= timer_ff.tcap_div;
      o_itmr_div <= timer_ff.itmr_div;
      o_xtal_enable <= pin_cfg_ff[CSSR_XTAL_EN];
      o_ext_from_xtal <= pin_cfg_ff[CSSR_XTAL_SEL];
      o_clock_input_pin_from_xtal <= pin_cfg_ff[CSSR_XTAL_EN];
      o_pin_oe_force_off <= pin_cfg_ff[CSSR_XTAL_EN];
      o_filter_bypass <= pin_cfg_ff[CSSR_FILT_DIS];
      o_clock_output_pin_sel <= pin_cfg_ff[1:0];
      // speed code 0 is divide by eight
      o_cpu_speed <= speed_ff;
      o_fetch_addr <= CSSR_RESET_VECTOR;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  a_lock_blocks: assert property (@(posedge i_clock) disable iff (!rst_n_ff)
    (lock_ff[CSSR_LOCK_DIS] && trim_st_ff == CSSR_IDLE) |=> trim_st_ff == CSSR_IDLE)
    else $error("trim started while lock disabled");
  a_ext_no_trim: assert property (@(posedge i_clock) disable iff (!rst_n_ff)
    (cpu_ff[CSSR_USB_SEL] && trim_st_ff == CSSR_IDLE) |=> trim_st_ff == CSSR_IDLE)
    else $error("trim started with external engine clock");
  a_fine_only: assert property (@(posedge i_clock) disable iff (!rst_n_ff)
    (trim_st_ff == CSSR_IDLE && trim_ok && lock_ff[CSSR_FINE_ONLY] && !soft_rst)
    |=> trim_st_ff == CSSR_FINE) else $error("coarse step ran in fine-only");
  a_sleep_force: assert property (@(posedge i_clock) disable iff (!rst_n_ff)
    sleep_s |=> !cpu_ff[CSSR_CPU_SEL] && !osc_run_ff)
    else $error("sleep did not force oscillator");
  a_xtal_pins: assert property (@(posedge i_clock) disable iff (!rst_n_ff)
    $past(rst_n_ff) |-> o_pin_oe_force_off == $past(pin_cfg_ff[CSSR_XTAL_EN])
    && o_clock_input_pin_from_xtal == $past(pin_cfg_ff[CSSR_XTAL_EN]))
    else $error("pin enables not forced with crystal");
  a_clock_output_pin_sel: assert property (@(posedge i_clock) disable iff (!rst_n_ff)
    $past(rst_n_ff) |-> o_clock_output_pin_sel == $past(pin_cfg_ff[1:0]))
    else $error("clock output select mismatch");
  a_wdr_flag: assert property (@(posedge i_clock) disable iff (!rst_n_ff)
    wdr_rise |=> wdr_seen_ff && timer_ff == CSSR_RST_TIMER)
    else $error("watchdog reset not recorded");
  a_vector: assert property (@(posedge i_clock) disable iff (!rst_n_ff)
    o_fetch_addr == CSSR_RESET_VECTOR) else $error("fetch address not vector");
endmodule : cssr_top
`default_nettype wire

// ===== cssr_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// far side: packet reference and low-power ticks
// ****
module cssr_partner (
  input wire logic i_clock,
  output logic o_packet_edge,
  output logic o_packet_slow,
  output logic o_lpo_tick
);
  initial begin
    o_packet_edge = 1'b0;
    o_packet_slow = 1'b0;
    o_lpo_tick = 1'b0;
  end
  // the level only means something around the edge
  task automatic packet(input logic slow);
    @(posedge i_clock) o_packet_slow <= slow;
    repeat (2) @(posedge i_clock);
    o_packet_edge <= 1'b1;
    repeat (4) @(posedge i_clock);
    o_packet_edge <= 1'b0;
    repeat (4) @(posedge i_clock);
    // released: show the inverse, never the stale level
    o_packet_slow <= ~slow;
  endtask : packet
  task automatic lpo(input int n);
    repeat (n) begin
      @(posedge i_clock) o_lpo_tick <= 1'b1;
      repeat (4) @(posedge i_clock);
      o_lpo_tick <= 1'b0;
      repeat (4) @(posedge i_clock);
    end
  endtask : lpo
endmodule : cssr_partner
`default_nettype wire

// ===== cssr_bench.sv
`timescale 1ns/100ps
`default_nettype none
module cssr_bench
  import cssr_pkg::*;
;
  logic i_clock, i_resetn, i_watchdog_reset, i_por_flag, i_sleep;
  logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [31:0] i_awaddr, i_wdata, i_araddr, o_rdata;
  logic [3:0] i_wstrb;
  logic i_packet_edge, i_packet_slow, i_lpo_tick;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_osc_run, o_cpu_on_ext;
  logic o_xtal_enable, o_ext_from_xtal, o_clock_input_pin_from_xtal, o_pin_oe_force_off, o_filter_bypass;
  logic [1:0] o_bresp, o_rresp, o_tcap_sel, o_tcap_div, o_itmr_sel, o_itmr_div, o_clock_output_pin_sel;
  logic [2:0] o_cpu_speed;
  logic [15:0] o_fetch_addr;
  logic [7:0] o_osc_trim, t;
  int fails, check_count;
  cssr_top i_dut (.i_clock, .i_resetn, .i_watchdog_reset, .i_por_flag, .i_awaddr, .i_awvalid,
    .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_packet_edge,
    .i_packet_slow, .i_sleep, .i_lpo_tick, .o_osc_trim, .o_osc_run, .o_cpu_on_ext, .o_tcap_sel,
    .o_tcap_div, .o_itmr_sel, .o_itmr_div, .o_xtal_enable, .o_ext_from_xtal, .o_clock_input_pin_from_xtal,
    .o_pin_oe_force_off, .o_filter_bypass, .o_clock_output_pin_sel, .o_cpu_speed, .o_fetch_addr);
  cssr_partner i_partner (.i_clock, .o_packet_edge(i_packet_edge),
    .o_packet_slow(i_packet_slow), .o_lpo_tick(i_lpo_tick));
  always #5 i_clock = ~i_clock;
  // ****
  // checking and bus tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // both channels offered together; each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    i_awaddr <= {22'h0, a, 2'h0};
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1 && n < 100);
    i_bready <= 1'b0;
    chk("bvalid", o_bvalid, 1'b1);
    chk("bresp", o_bresp, er);
    @(posedge i_clock);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    i_araddr <= {22'h0, a, 2'h0};
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
    end while (o_rvalid !== 1'b1 && n < 100);
    i_rready <= 1'b0;
    chk("rvalid", o_rvalid, 1'b1);
    chk($sformatf("rdata at %h", a), o_rdata, exp);
    chk("rresp", o_rresp, er);
    @(posedge i_clock);
  endtask : rd
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // tests need about five hundred cycles; this leaves a wide margin
  initial begin
    #500000;
    fails++;
    conclude();
  end
  // ****
  // tests
  // ****
  initial begin
    {i_clock, i_resetn, i_watchdog_reset, i_sleep} = 4'h0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    {i_awaddr, i_wdata, i_araddr} = 96'h0;
    i_wstrb = 4'hF;
    i_por_flag = 1'b1;
    repeat (12) @(posedge i_clock);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clock);
    i_por_flag <= 1'b0;
    rd(CSSR_OFF_TIMER, CSSR_RST_TIMER, CSSR_AXI_OKAY);
    rd(CSSR_OFF_PIN, 8'h00, CSSR_AXI_OKAY);
    rd(CSSR_OFF_LOCK, 8'h00, CSSR_AXI_OKAY);
    rd(CSSR_OFF_SPEED, 8'h00, CSSR_AXI_OKAY);
    rd(CSSR_OFF_VECTOR, 16'h0000, CSSR_AXI_OKAY);
    rd(CSSR_OFF_STATUS, 8'h01, CSSR_AXI_OKAY);
    chk("fetch", o_fetch_addr, 16'h0000);
    chk("cpu_ext", o_cpu_on_ext, 1'b0);
    chk("speed", o_cpu_speed, 3'h0);
    rd(8'h50, 32'h0, CSSR_AXI_SLVERR);
    wr(8'h50, 32'hFF, CSSR_AXI_SLVERR);
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      wr(CSSR_OFF_TIMER, {4{c[1:0]}}, CSSR_AXI_OKAY);
      chk("itmr_div", o_itmr_div, c[1:0]);
      chk("itmr_sel", o_itmr_sel, c[1:0]);
      chk("tcap_sel", o_tcap_sel, c[1:0]);
      chk("tcap_div", o_tcap_div, c[1:0]);
      wr(CSSR_OFF_PIN, c[1:0], CSSR_AXI_OKAY);
      chk("clock_output_pin", o_clock_output_pin_sel, c[1:0]);
    end
    $display("test selects done");
    // crystal on first, select only after startup
    wr(CSSR_OFF_PIN, 8'h08, CSSR_AXI_OKAY);
    chk("xtal_en", o_xtal_enable, 1'b1);
    chk("clock_input_pin_xtal", o_clock_input_pin_from_xtal, 1'b1);
    chk("oe_off", o_pin_oe_force_off, 1'b1);
    chk("ext_xtal", o_ext_from_xtal, 1'b0);
    // shortened stand-in for the crystal startup time
    repeat (200) @(posedge i_clock);
    wr(CSSR_OFF_PIN, 8'h18, CSSR_AXI_OKAY);
    chk("ext_xtal", o_ext_from_xtal, 1'b1);
    wr(CSSR_OFF_PIN, 8'h08, CSSR_AXI_OKAY);
    wr(CSSR_OFF_PIN, 8'hE4, CSSR_AXI_OKAY);
    chk("clock_input_pin_xtal", o_clock_input_pin_from_xtal, 1'b0);
    chk("oe_off", o_pin_oe_force_off, 1'b0);
    chk("bypass", o_filter_bypass, 1'b1);
    rd(CSSR_OFF_PIN, 8'h04, CSSR_AXI_OKAY);
    wr(CSSR_OFF_PIN, 8'h00, CSSR_AXI_OKAY);
    chk("bypass", o_filter_bypass, 1'b0);
    $display("test pins done");
    i_partner.packet(1'b1);
    repeat (4) @(posedge i_clock);
    chk("coarse", o_osc_trim > 8'h81, 1'b1);
    t = o_osc_trim;
    // fine-only once coarse tuning has settled
    wr(CSSR_OFF_LOCK, 8'h02, CSSR_AXI_OKAY);
    i_partner.packet(1'b1);
    repeat (4) @(posedge i_clock);
    chk("fine_up", o_osc_trim, t + 8'h01);
    i_partner.packet(1'b0);
    repeat (4) @(posedge i_clock);
    chk("fine_dn", o_osc_trim, t);
    wr(CSSR_OFF_LOCK, 8'h03, CSSR_AXI_OKAY);
    i_partner.packet(1'b1);
    repeat (4) @(posedge i_clock);
    chk("lock_off", o_osc_trim, t);
    wr(CSSR_OFF_LOCK, 8'h02, CSSR_AXI_OKAY);
    wr(CSSR_OFF_CPU, 8'h20, CSSR_AXI_OKAY);
    i_partner.packet(1'b1);
    repeat (4) @(posedge i_clock);
    chk("usb_ext", o_osc_trim, t);
    $display("test trim done");
    wr(CSSR_OFF_CPU, 8'h01, CSSR_AXI_OKAY);
    i_sleep <= 1'b1;
    repeat (6) @(posedge i_clock);
    chk("sleep_cpu", o_cpu_on_ext, 1'b0);
    chk("sleep_osc", o_osc_run, 1'b0);
    i_sleep <= 1'b0;
    i_partner.lpo(2);
    chk("wake2", o_osc_run, 1'b0);
    i_partner.lpo(1);
    chk("wake3", o_osc_run, 1'b1);
    rd(CSSR_OFF_CPU, 8'h00, CSSR_AXI_OKAY);
    wr(CSSR_OFF_CPU, 8'h21, CSSR_AXI_OKAY);
    chk("cpu_ext", o_cpu_on_ext, 1'b1);
    $display("test sleep done");
    wr(CSSR_OFF_TIMER, 8'h00, CSSR_AXI_OKAY);
    wr(CSSR_OFF_SPEED, 8'h03, CSSR_AXI_OKAY);
    chk("speed", o_cpu_speed, 3'h3);
    i_watchdog_reset <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_watchdog_reset <= 1'b0;
    repeat (8) @(posedge i_clock);
    rd(CSSR_OFF_TIMER, CSSR_RST_TIMER, CSSR_AXI_OKAY);
    rd(CSSR_OFF_CPU, 8'h00, CSSR_AXI_OKAY);
    rd(CSSR_OFF_SPEED, 8'h00, CSSR_AXI_OKAY);
    rd(CSSR_OFF_STATUS, 8'h03, CSSR_AXI_OKAY);
    wr(CSSR_OFF_STATUS, 8'h03, CSSR_AXI_OKAY);
    rd(CSSR_OFF_STATUS, 8'h00, CSSR_AXI_OKAY);
    $display("test watchdog done");
    // a cleared byte strobe leaves the register alone but still answers OKAY
    i_wstrb <= 4'h0;
    wr(CSSR_OFF_LOCK, 8'h03, CSSR_AXI_OKAY);
    i_wstrb <= 4'hF;
    rd(CSSR_OFF_LOCK, 8'h00, CSSR_AXI_OKAY);
    // second power-on in mid-run
    wr(CSSR_OFF_PIN, 8'h1F, CSSR_AXI_OKAY);
    i_por_flag <= 1'b1;
    i_resetn <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clock);
    i_por_flag <= 1'b0;
    rd(CSSR_OFF_PIN, CSSR_RST_PIN, CSSR_AXI_OKAY);
    rd(CSSR_OFF_STATUS, 8'h01, CSSR_AXI_OKAY);
    chk("bypass", o_filter_bypass, 1'b0);
    chk("xtal_en", o_xtal_enable, 1'b0);
    $display("test second reset done");
    conclude();
  end
endmodule : cssr_bench
`default_nettype wire
